/* hw/scb_capture.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scb_defs.svh"

// Function
// - Segmented mode splits memory, one trigger each
// - Active segment stores a sample every clock the write FIFO has room
// - Finished segment advances to the next one
// - Next segment trigger evaluated right after trigger
// - Next trigger or post-fill end starts next
// - Trigger events from sequential or custom flow
// - Sequential flow uses one position for all
// - Ten percent before trigger, ninety after
// - Unwritten locations stay empty; trigger start skips pre
// - Custom commands close segment and advance capture
module scb_capture
	import scb_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int TOTAL_DEPTH = `SCB_TOTAL_DEPTH,
	parameter int MAX_SEGS = `SCB_MAX_SEGS,
	parameter int FIFO_DEPTH = `SCB_FIFO_DEPTH
) (
	input wire logic mclk, // Acquisition clock, 20 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic arm, // Start an acquisition (pulse)
	input wire logic seg_en, // Segmented mode enable
	input wire logic [3:0] seg_log2, // Segment count as a power of two
	input wire logic flow_sel, // 0 sequential flow, 1 custom flow
	input wire logic seq_hit, // Sequential condition of the evaluated segment met
	input wire logic seg_trig_cmd, // Custom flow segment-trigger command
	input wire logic trig_cmd, // Custom flow trigger command
	input wire logic [DATA_W-1:0] probe, // Probed design signals
	input wire logic mem_ready, // Capture memory accepts a write
	output logic mem_valid, // Capture memory write request
	output logic [$clog2(TOTAL_DEPTH)-1:0] mem_addr, // Capture memory write address
	output logic [DATA_W-1:0] mem_data, // Capture memory write data
	output logic busy, // Acquisition in progress
	output logic done, // All segments captured
	output logic [$clog2(MAX_SEGS):0] act_seg, // Segment being written
	output logic [$clog2(MAX_SEGS):0] eval_seg // Segment whose trigger is evaluated
);
	localparam int AW = $clog2(TOTAL_DEPTH);
	localparam int SW = $clog2(MAX_SEGS) + 1;
	localparam int FW = AW + DATA_W;
	localparam logic [3:0] MAX_LOG = 4'($clog2(MAX_SEGS));

	// ****************************************
	// Segment geometry
	// ****************************************

	// Depth of one segment; segments tile the total depth exactly
	function automatic logic [AW:0] seg_depth(input logic [3:0] sh);
		seg_depth = (AW + 1)'(TOTAL_DEPTH) >> sh;
	endfunction

	// Pre-trigger share of one segment, rounded down
	function automatic logic [AW:0] pre_len(input logic [3:0] sh);
		int d;
		d = int'(seg_depth(sh));
		pre_len = (AW + 1)'((d * `SCB_PRE_PCT) / `SCB_FULL_PCT);
	endfunction

	// First address of a segment
	function automatic logic [AW-1:0] seg_base(input logic [SW-1:0] s, input logic [3:0] sh);
		logic [AW+SW-1:0] w;
		w = (AW + SW)'(s) << (4'(AW) - sh);
		seg_base = w[AW-1:0];
	endfunction

	// ****************************************
	// Sequencer state
	// ****************************************
	scb_state_e st_r, st_nxt;
	logic [3:0] sh_r, sh_nxt;
	logic [SW-1:0] seg_r, seg_nxt, ev_r, ev_nxt;
	logic [AW:0] off_r, off_nxt, cnt_r, cnt_nxt;
	logic busy_r, busy_nxt, done_r, done_nxt;
	logic [AW-1:0] waddr;
	logic push, hit, last_seg;
	logic [AW:0] sdep, plen, postl;

	scb_stream_if #(.WIDTH(FW)) wr_s ();
	scb_stream_if #(.WIDTH(FW)) rd_s ();
	logic mv_r, mv_nxt;
	logic [AW-1:0] ma_r, ma_nxt;
	logic [DATA_W-1:0] md_r, md_nxt;

	assign sdep = seg_depth(sh_r);
	assign plen = pre_len(sh_r);
	assign postl = sdep - plen;
	assign last_seg = (seg_r == SW'((1 << sh_r) - 1));

	// Trigger source picked by flow; one position setting serves every segment
	// flow selection
	assign hit = (flow_sel == SCB_FLOW_CUSTOM) ? (seg_trig_cmd || trig_cmd) : seq_hit;

	// Sample goes to the FIFO; a full FIFO stalls the sequencer in place
	assign wr_s.valid = push;
	assign wr_s.data = {waddr, probe};

	// Next-state logic of the capture sequencer
	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		seg_nxt = seg_r;
		ev_nxt = ev_r;
		off_nxt = off_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = done_r;
		push = 1'b0;
		waddr = seg_base(seg_r, sh_r) + off_r[AW-1:0];
		unique case (st_r)
			SCB_IDLE, SCB_DONE: begin
				if (arm) begin
					sh_nxt = !seg_en ? 4'h0 : (seg_log2 > MAX_LOG) ? MAX_LOG : seg_log2;
					seg_nxt = '0;
					ev_nxt = '0;
					off_nxt = '0;
					st_nxt = SCB_PRE;
					busy_nxt = 1'b1;
					done_nxt = 1'b0;
				end
			end
			SCB_PRE: begin
				push = wr_s.ready;
				if (wr_s.ready) begin
					off_nxt = (off_r == sdep - 1'b1) ? '0 : off_r + 1'b1;
					if (hit) begin
						cnt_nxt = postl - 1'b1;
						ev_nxt = seg_r + 1'b1;
						st_nxt = SCB_POST;
					end
				end
			end
			SCB_POST: begin
				push = wr_s.ready;
				if (wr_s.ready && hit && !last_seg) begin
					seg_nxt = seg_r + 1'b1;
					waddr = seg_base(seg_r + 1'b1, sh_r) + plen[AW-1:0];
					off_nxt = plen + 1'b1;
					cnt_nxt = postl - 1'b1;
					ev_nxt = seg_r + 2'd2;
				end else if (wr_s.ready) begin
					off_nxt = (off_r == sdep - 1'b1) ? '0 : off_r + 1'b1;
					cnt_nxt = cnt_r - 1'b1;
					if (cnt_r == (AW + 1)'(1)) begin
						if (last_seg) begin
							st_nxt = SCB_DONE;
							busy_nxt = 1'b0;
							done_nxt = 1'b1;
						end else begin
							seg_nxt = seg_r + 1'b1;
							off_nxt = '0;
							st_nxt = SCB_PRE;
						end
					end
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_r <= SCB_IDLE;
			sh_r <= `SCB_SEGLOG_RST;
			seg_r <= '0;
			ev_r <= '0;
			off_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			seg_r <= seg_nxt;
			ev_r <= ev_nxt;
			off_r <= off_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	// ****************************************
	// Write buffering toward the capture memory
	// ****************************************

	// Absorbs short memory stalls; a long stall pauses capture
	scb_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst_n(resetn),
		.wr(wr_s),
		.rd(rd_s)
	);

	// Output stage refills when empty or taken, so the memory port never sees the read mux
	assign rd_s.ready = !mv_r || mem_ready;

	// Next values of the output stage; a word waiting on a stall holds still
	always_comb begin
		mv_nxt = mv_r;
		ma_nxt = ma_r;
		md_nxt = md_r;
		if (rd_s.ready) begin
			mv_nxt = rd_s.valid;
		end
		if (rd_s.ready && rd_s.valid) begin
			ma_nxt = rd_s.data[FW-1:DATA_W];
			md_nxt = rd_s.data[DATA_W-1:0];
		end
	end

	// Output stage registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mv_r <= 1'b0;
			ma_r <= '0;
			md_r <= '0;
		end else begin
			mv_r <= mv_nxt;
			ma_r <= ma_nxt;
			md_r <= md_nxt;
		end
	end

	// Status outputs straight from the sequencer flops
	assign busy = busy_r;
	assign done = done_r;
	assign act_seg = seg_r;
	assign eval_seg = ev_r;
	// Memory write port from the output stage flops
	assign mem_valid = mv_r;
	assign mem_addr = ma_r;
	assign mem_data = md_r;
endmodule

`default_nettype wire

/* hw/scb_defs.svh */
`ifndef SCB_DEFS_SVH
`define SCB_DEFS_SVH

// ****************************************
// Capture position and buffering constants
// ****************************************
// Share of each segment kept for samples before the trigger, in percent
`define SCB_PRE_PCT 10
// Whole segment, in percent
`define SCB_FULL_PCT 100
// Default total sample depth of the capture memory
`define SCB_TOTAL_DEPTH 1024
// Default largest segment count
`define SCB_MAX_SEGS 16
// Default depth of the write FIFO, in words
`define SCB_FIFO_DEPTH 16
// Reset value of the segment-count setting (one segment)
`define SCB_SEGLOG_RST 4'h0

`endif

/* hw/scb_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Flip-flop FIFO with valid/ready on both sides
// ****************************************
module scb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Asynchronous reset, active low
	scb_stream_if.snk wr, // Filling side
	scb_stream_if.src rd // Draining side
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Full and empty come straight from the held count
	assign wr.ready = (cnt_r != CW'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data = mem_r[rp_r];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;

	// Pointer and count update, wrapping for any depth
	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage needs no reset; nothing reads a word before it is written
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= wr.data;
		end
	end
endmodule

`default_nettype wire

/* hw/scb_pkg.sv */
// ****************************************
// Types shared by the capture buffer
// ****************************************
package scb_pkg;

	// Capture sequencer states
	typedef enum logic [1:0] {
		SCB_IDLE = 2'b00,
		SCB_PRE = 2'b01,
		SCB_POST = 2'b10,
		SCB_DONE = 2'b11
	} scb_state_e;

	// Source of the per-segment trigger events
	typedef enum logic {
		SCB_FLOW_SEQ = 1'b0,
		SCB_FLOW_CUSTOM = 1'b1
	} scb_flow_e;

endpackage

/* hw/scb_stream_if.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Valid/ready word stream between modules
// ****************************************
interface scb_stream_if #(
	parameter int WIDTH = 8
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	// Producer drives valid and data, consumer drives ready
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

/* test/scb_capture_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Capture checker
// ****************
module scb_capture_chk #(
	parameter int DATA_W = 16,
	parameter int TOTAL_DEPTH = 1024,
	parameter int MAX_SEGS = 16
) (
	input wire logic mclk, // Clock
	input wire logic resetn, // Reset, low
	input wire logic arm, // Start
	input wire logic mem_ready, // Write taken
	input wire logic mem_valid, // Write request
	input wire logic [$clog2(TOTAL_DEPTH)-1:0] mem_addr, // Address
	input wire logic [DATA_W-1:0] mem_data, // Data
	input wire logic busy, // Running
	input wire logic done, // Finished
	input wire logic [$clog2(MAX_SEGS):0] act_seg, // Written segment
	input wire logic [$clog2(MAX_SEGS):0] eval_seg // Evaluated segment
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_wait; mem_valid && !mem_ready; endsequence
	sequence s_run; $past(busy) && busy; endsequence
	property p_arm; !busy && arm |=> busy; endproperty
	property p_excl; !(busy && done); endproperty
	property p_hold; done && !arm |=> done; endproperty
	property p_end; $past(busy) && !busy |-> done; endproperty
	property p_stall; s_wait |=> mem_valid && $stable(mem_addr) && $stable(mem_data); endproperty
	property p_lead; busy |-> eval_seg - act_seg <= 1; endproperty
	property p_seg; s_run ##0 $changed(act_seg) |-> act_seg == $past(act_seg) + 1; endproperty
	property p_eval; s_run ##0 $changed(eval_seg) |-> eval_seg == $past(eval_seg) + 1; endproperty
	a_arm: assert property (p_arm) else $error("no start");
	a_excl: assert property (p_excl) else $error("busy and done");
	a_hold: assert property (p_hold) else $error("done dropped");
	a_end: assert property (p_end) else $error("end without done");
	a_stall: assert property (p_stall) else $error("write changed");
	a_lead: assert property (p_lead) else $error("eval not ahead");
	a_seg: assert property (p_seg) else $error("segment skip");
	a_eval: assert property (p_eval) else $error("eval skip");
endmodule

bind scb_capture scb_capture_chk #(.DATA_W(DATA_W), .TOTAL_DEPTH(TOTAL_DEPTH),
	.MAX_SEGS(MAX_SEGS)) chk_u (.mclk, .resetn, .arm, .mem_ready, .mem_valid,
	.mem_addr, .mem_data, .busy, .done, .act_seg, .eval_seg);
`default_nettype wire

/* test/scb_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Capture memory
// ****************
module scb_mem_model (
	input wire logic mclk, // Clock
	input wire logic resetn, // Reset, low
	input wire logic stall, // Slow acceptance
	input wire logic mem_valid, // Write request
	input wire logic [9:0] mem_addr, // Address
	input wire logic [15:0] mem_data, // Data
	output logic mem_ready, // Write taken
	output int n_wr, // Writes taken
	output logic [9:0] last_addr, // Last address
	output logic [15:0] last_data // Last data
);
	logic [1:0] ph_r;
	// One cycle in four when stalling, so the FIFO fills up
	assign mem_ready = !stall || ph_r == 2'h0;
	// Count taken writes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ph_r <= 2'h0;
			n_wr <= 0;
			last_addr <= 10'h000;
			last_data <= 16'h0000;
		end else begin
			ph_r <= ph_r + 2'h1;
			if (mem_valid && mem_ready) begin
				n_wr <= n_wr + 1;
				last_addr <= mem_addr;
				last_data <= mem_data;
			end
		end
	end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module tb;
	import scb_pkg::*;
	logic mclk, resetn, arm, seg_en, flow_sel, seq_hit, seg_trig_cmd, trig_cmd;
	logic mem_ready, mem_valid, busy, done, stall;
	logic [3:0] seg_log2;
	logic [1:0] hs;
	logic [15:0] probe, mem_data, last_data, p0;
	logic [9:0] mem_addr, last_addr;
	logic [4:0] act_seg, eval_seg;
	int n_wr, mismatches, n_compared, s, d, p, base, i, q;
	// Rows: enable, stall, flow, trigger source, segment count log2
	logic [8:0] rows [6] = '{9'h102, 9'h181, 9'h153, 9'h164, 9'h002, 9'h180};
	scb_capture dut_u (.mclk, .resetn, .arm, .seg_en, .seg_log2, .flow_sel,
		.seq_hit, .seg_trig_cmd, .trig_cmd, .probe, .mem_ready, .mem_valid,
		.mem_addr, .mem_data, .busy, .done, .act_seg, .eval_seg);
	scb_mem_model mem_u (.mclk, .resetn, .stall, .mem_valid, .mem_addr,
		.mem_data, .mem_ready, .n_wr, .last_addr, .last_data);
	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Moving probe pattern
	always @(posedge mclk) probe <= resetn ? probe + 16'h1 : 16'h0;
	task cyc(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task end_of_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Bounded wait for the end of capture and a drained write path (quiet for 3 cycles)
	task wait_end();
		q = 0;
		for (i = 0; i < 5000 && q < 3; i++) begin
			cyc(1);
			q = (done === 1'b1 && mem_valid === 1'b0) ? q + 1 : 0;
		end
		if (q < 3) begin
			mismatches++;
			end_of_test();
		end
	endtask
	initial begin
		{resetn, arm, seg_en, flow_sel, seq_hit, seg_trig_cmd, trig_cmd, stall} = 8'h00;
		seg_log2 = 4'h0;
		mismatches = 0;
		n_compared = 0;
		cyc(2);
		resetn = 1'b1;
		// Back-to-back triggers: every segment but the last is preempted
		foreach (rows[r]) begin
			{seg_en, stall, flow_sel, hs, seg_log2} = rows[r];
			seq_hit = hs == 2'h0;
			seg_trig_cmd = hs == 2'h1;
			trig_cmd = hs == 2'h2;
			s = seg_en ? 1 << seg_log2 : 1;
			d = 1024 / s;
			p = d * 10 / 100;
			base = n_wr;
			arm = 1'b1;
			cyc(1);
			arm = 1'b0;
			p0 = probe;
			wait_end();
			`CHK(n_wr - base, s - 1 + d - p)
			`CHK(last_addr, 10'(s == 1 ? d - p - 1 : s * d - 1))
			`CHK(act_seg, 5'(s - 1))
			`CHK(busy, 1'b0)
			`CHK(eval_seg, 5'(s))
			if (!stall) `CHK(last_data, 16'(p0 + s - 1 + d - p - 1))
		end
		// Reset in mid-capture clears the sequencer
		seq_hit = 1'b0;
		arm = 1'b1;
		cyc(5);
		resetn = 1'b0;
		#1;
		`CHK({busy, done, mem_valid, act_seg}, 8'h00)
		// Second release: the sequencer stays idle until the next start
		cyc(1);
		arm = 1'b0;
		resetn = 1'b1;
		cyc(2);
		`CHK({busy, done, mem_valid, act_seg, eval_seg}, 13'h0000)
		end_of_test();
	end
endmodule
`default_nettype wire
